/* File: core/pad_mux_pkg.sv */
// Shared constants for the pad function multiplexer
package pad_mux_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W     = 12;              // Byte address width of the slave
    localparam int DATA_W     = 32;              // AXI4-Lite data width
    localparam int WORD_BYTES = 4;               // One register per aligned word

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] PAD_CFG_BASE = 12'h000; // First pad configuration word
    localparam logic [ADDR_W-1:0] PAD_IN_ADDR  = 12'h100; // Synchronised pad input levels

    // ----------------------------------------
    // Pad configuration word layout
    // ----------------------------------------
    localparam int MODE_W      = 4;              // Function mode field width
    localparam int MODE_LSB    = 0;              // Mode field position
    localparam int DRIVE_LSB   = 4;              // Drive strength field position
    localparam int PULL_UP_BIT = 6;              // Weak pull-up enable
    localparam int PULL_DN_BIT = 7;              // Weak pull-down enable
    localparam int CFG_W       = 8;              // Stored bits per pad

    // Drive strength codes, three legal levels
    typedef enum logic [1:0]
    {
        DRIVE_2MA = 2'b00,
        DRIVE_4MA = 2'b01,
        DRIVE_6MA = 2'b10
    } drive_t;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [CFG_W-1:0]  CFG_RESET = 8'h00; // Mode 0, 2 mA, no pulls
    localparam logic [MODE_W-1:0] MODE_ZERO = 4'h0;  // Default function mode

    // ----------------------------------------
    // AXI response codes
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pad_mux_pkg

/* File: core/pad_function_mux.sv */
// Per-pad function multiplexer with AXI4-Lite configuration registers
`timescale 1ns/1ps
module pad_function_mux
    import pad_mux_pkg::*;
#(
    parameter int NUM_PADS = 16                  // Number of multiplexed pads
)
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite slave
    input  wire logic [pad_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pad_mux_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pad_mux_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [pad_mux_pkg::DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Peripheral function side, pad p mode m at bit p*16+m
    input  wire logic [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] func_out,
    input  wire logic [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] func_oe,
    output logic      [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] func_in,
    // Pad side
    input  wire logic [NUM_PADS-1:0]           pad_in,
    output logic      [NUM_PADS-1:0]           pad_out,
    output logic      [NUM_PADS-1:0]           pad_oe,
    output logic      [2*NUM_PADS-1:0]         pad_drive,
    output logic      [NUM_PADS-1:0]           pad_pull_up,
    output logic      [NUM_PADS-1:0]           pad_pull_dn
);
    import pad_mux_pkg::*;

    // ----------------------------------------
    // Local constants and helpers
    // ----------------------------------------
    localparam int NUM_MODES = 2**MODE_W;        // Functions per pad
    localparam int IDX_W     = $clog2(NUM_PADS); // Pad index width
    localparam logic [ADDR_W-1:0] PAD_CFG_END =
        ADDR_W'(int'(PAD_CFG_BASE) + NUM_PADS*WORD_BYTES);

    // True for an aligned address inside the pad configuration block
    function automatic logic addr_is_pad(input logic [ADDR_W-1:0] a);
        addr_is_pad = (a[1:0] == 2'b00) && (a >= PAD_CFG_BASE) && (a < PAD_CFG_END);
    endfunction : addr_is_pad

    // Pad index of a configuration address
    function automatic logic [IDX_W-1:0] pad_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off       = a - PAD_CFG_BASE;
        pad_index = off[IDX_W+1:2];
    endfunction : pad_index

    // Saturate the unused code so only three drive levels reach a pad
    function automatic logic [1:0] drive_level(input logic [1:0] code);
        drive_level = (code == 2'b11) ? DRIVE_6MA : code;
    endfunction : drive_level

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [CFG_W-1:0]   cfg_ff [NUM_PADS];       // Per-pad configuration words
    logic [NUM_PADS-1:0] pad_meta_ff;            // First synchroniser stage
    logic [NUM_PADS-1:0] pad_sync_ff;            // Second synchroniser stage
    logic                aw_held_ff;             // Write address captured
    logic [ADDR_W-1:0]   aw_addr_ff;             // Captured write address
    logic                w_held_ff;              // Write data captured
    logic [DATA_W-1:0]   w_data_ff;              // Captured write data
    logic                w_strb0_ff;             // Low byte lane enabled
    logic                bvalid_ff;              // Write response pending
    logic [1:0]          bresp_ff;               // Write response code
    logic                rvalid_ff;              // Read response pending
    logic [1:0]          rresp_ff;               // Read response code
    logic [DATA_W-1:0]   rdata_ff;               // Read data
    logic [NUM_PADS-1:0] pad_out_ff;             // Registered pad output value
    logic [NUM_PADS-1:0] pad_oe_ff;              // Registered pad output enable
    logic [2*NUM_PADS-1:0] pad_drive_ff;         // Registered drive codes
    logic [NUM_PADS-1:0] pull_up_ff;             // Registered pull-up enables
    logic [NUM_PADS-1:0] pull_dn_ff;             // Registered pull-down enables
    logic [NUM_PADS*NUM_MODES-1:0] func_in_ff;   // Registered inputs to functions

    // ----------------------------------------
    // Bus handshakes and decode
    // ----------------------------------------
    // One write in flight; both channels stall while the response waits
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held_ff && w_held_ff;
    wire wr_pad   = addr_is_pad(aw_addr_ff);
    wire [IDX_W-1:0] wr_idx = pad_index(aw_addr_ff);
    wire cfg_we   = do_write && wr_pad && w_strb0_ff;
    wire ar_take  = s_axi_arvalid && s_axi_arready;
    wire rd_pad   = addr_is_pad(s_axi_araddr);
    wire rd_in    = (s_axi_araddr == PAD_IN_ADDR);
    wire [IDX_W-1:0] rd_idx = pad_index(s_axi_araddr);
    wire wr_ok    = wr_pad || (aw_addr_ff == PAD_IN_ADDR);

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;

    // Read data selection: config word, pad levels, or zero
    wire [DATA_W-1:0] rd_word =
        rd_pad ? {{(DATA_W-CFG_W){1'b0}}, cfg_ff[rd_idx]} :
        rd_in  ? {{(DATA_W-NUM_PADS){1'b0}}, pad_sync_ff} :
                 {DATA_W{1'b0}};
    wire [1:0] rd_resp = (rd_pad || rd_in) ? RESP_OKAY : RESP_SLVERR;

    // ----------------------------------------
    // Write channel capture and response
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'b0;
            w_data_ff  <= '0;
            w_strb0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end
        else
        begin
            // Address and data may arrive in either order
            if (aw_take)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata;
                w_strb0_ff <= s_axi_wstrb[0];
            end
            // Commit and answer once both halves are in
            if (do_write)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
        end
        else if (ar_take)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_resp;
            rdata_ff  <= rd_word;
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Reset value is the hardware part of the selection; any mode is accepted,
    // nothing checks it against other pads (boot code owns consistency)
    always_ff @(posedge aclk)
    begin
        for (int p = 0; p < NUM_PADS; p++)
        begin
            if (!aresetn)
                cfg_ff[p] <= CFG_RESET;
            else if (cfg_we && (wr_idx == IDX_W'(p)))
                cfg_ff[p] <= w_data_ff[CFG_W-1:0];
        end
    end

    // ----------------------------------------
    // Pad input synchroniser
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_meta_ff <= '0;
            pad_sync_ff <= '0;
        end
        else
        begin
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // ----------------------------------------
    // Function selection per pad
    // ----------------------------------------
    logic [NUM_PADS-1:0]           nxt_pad_out;   // Selected function output
    logic [NUM_PADS-1:0]           nxt_pad_oe;    // Selected function enable
    logic [NUM_PADS*NUM_MODES-1:0] nxt_func_in;   // Steered pad input

    for (genvar p = 0; p < NUM_PADS; p++)
    begin : g_pad
        wire [MODE_W-1:0] mode = cfg_ff[p][MODE_LSB +: MODE_W];
        assign nxt_pad_out[p] = func_out[p*NUM_MODES + int'(mode)];
        assign nxt_pad_oe[p]  = func_oe[p*NUM_MODES + int'(mode)];
        for (genvar m = 0; m < NUM_MODES; m++)
        begin : g_mode
            // Unselected functions see a steady low
            assign nxt_func_in[p*NUM_MODES + m] =
                (mode == MODE_W'(m)) ? pad_sync_ff[p] : 1'b0;
        end
    end

    // ----------------------------------------
    // Registered pad and function outputs
    // ----------------------------------------
    // Output enables reset low so every pad is high-impedance until a
    // selected function asks to drive it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out_ff   <= '0;
            pad_oe_ff    <= '0;
            pad_drive_ff <= '0;
            pull_up_ff   <= '0;
            pull_dn_ff   <= '0;
            func_in_ff   <= '0;
        end
        else
        begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff  <= nxt_pad_oe;
            func_in_ff <= nxt_func_in;
            for (int p = 0; p < NUM_PADS; p++)
            begin
                pad_drive_ff[2*p +: 2] <= drive_level(cfg_ff[p][DRIVE_LSB +: 2]);
                pull_up_ff[p] <= cfg_ff[p][PULL_UP_BIT];
                pull_dn_ff[p] <= cfg_ff[p][PULL_DN_BIT];
            end
        end
    end

    assign pad_out     = pad_out_ff;
    assign pad_oe      = pad_oe_ff;
    assign pad_drive   = pad_drive_ff;
    assign pad_pull_up = pull_up_ff;
    assign pad_pull_dn = pull_dn_ff;
    assign func_in     = func_in_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire [MODE_W-1:0] pad0_mode = cfg_ff[0][MODE_LSB +: MODE_W];  // Helper view of pad 0

    sequence s_write_commit;
        cfg_we && (wr_idx == '0);
    endsequence

    sequence s_cfg_loaded;
        cfg_ff[0] == $past(w_data_ff[CFG_W-1:0]);
    endsequence

    a_mode_reset_zero: assert property (
        $rose(aresetn) |-> (pad0_mode == MODE_ZERO) && (pad_oe_ff == '0))
        else $error("pad mode not zero after reset");

    a_mode_held_idle: assert property (
        !cfg_we |=> $stable(cfg_ff[0]))
        else $error("pad config changed without a write");

    // The pull stage lags the config by one edge; a second write may overlap it
    a_write_loads_cfg: assert property (
        s_write_commit |=> s_cfg_loaded ##1
            ((pull_up_ff[0] == cfg_ff[0][PULL_UP_BIT]) || $past(cfg_we)))
        else $error("written config not applied to pad");

    a_pull_follows_cfg: assert property (
        1'b1 |=> (pull_up_ff[0] == $past(cfg_ff[0][PULL_UP_BIT])) &&
                 (pull_dn_ff[0] == $past(cfg_ff[0][PULL_DN_BIT])))
        else $error("pull enable does not follow config");

    a_drive_three_lvls: assert property (
        pad_drive_ff[1:0] != 2'b11)
        else $error("drive strength outside three levels");

    a_out_follows_mode: assert property (
        1'b1 |=> (pad_out_ff[0] == $past(func_out[int'(pad0_mode)])) &&
                 (pad_oe_ff[0] == $past(func_oe[int'(pad0_mode)])))
        else $error("pad does not carry selected function");

    a_func_in_onehot: assert property (
        $onehot0(func_in_ff[NUM_MODES-1:0]) &&
        ((func_in_ff[NUM_MODES-1:0] & ~(NUM_MODES'(1) << $past(pad0_mode))) == '0))
        else $error("unselected function sees active input");

    a_bresp_one_cycle: assert property (
        do_write |=> bvalid_ff ##0 (bresp_ff == (($past(wr_ok)) ? RESP_OKAY : RESP_SLVERR)))
        else $error("write response missing or wrong");

    a_rvalid_holds: assert property (
        rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
        else $error("read data dropped before accept");

endmodule : pad_function_mux

/* File: test/pad_partner.sv */
// Peripheral function units and package pads facing the pad multiplexer
`timescale 1ns/1ps
module pad_partner
    import pad_mux_pkg::*;
#(
    parameter int NUM_PADS = 4                                   // Pads modelled
)
(
    input  wire logic [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] out_pat,  // Function output values
    input  wire logic [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] oe_pat,   // Function enables
    input  wire logic [NUM_PADS-1:0]                          ext_lvl,  // Level the board drives
    output logic      [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] func_out,
    output logic      [NUM_PADS*(2**pad_mux_pkg::MODE_W)-1:0] func_oe,
    input  wire logic [NUM_PADS-1:0]                          pad_out,
    input  wire logic [NUM_PADS-1:0]                          pad_oe,
    output logic      [NUM_PADS-1:0]                          pad_in
);
    // ----------------------------------------
    // Function units
    // ----------------------------------------
    // Every unit drives at once, even clashing ones; nothing checks the choice
    assign func_out = out_pat;
    assign func_oe  = oe_pat;

    // ----------------------------------------
    // Pads
    // ----------------------------------------
    // A driven pad shows the chip's value; an undriven one the board's level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : pad_partner

/* File: test/pad_function_multiplexer_test.sv */
// Self-checking bench for the pad function multiplexer
`timescale 1ns/1ps
module pad_function_multiplexer_test;
    import pad_mux_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int NP = 4;                              // Small pad count keeps the run short
    localparam int NF = NP * 16;                        // Function lines, 16 modes per pad
    localparam logic [NF-1:0] PAT_O = 64'hA5C3_3C5A_0FF0_96E1; // Output pattern
    localparam logic [NF-1:0] PAT_E = 64'h5AF0_C33C_F00F_6996; // Enable pattern
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [NF-1:0]     func_out, func_oe, func_in, out_pat, oe_pat;
    logic [NP-1:0]     pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn, ext_lvl;
    logic [2*NP-1:0]   pad_drive;
    logic [7:0]        cfg_exp [NP];                    // Expected config byte per pad
    logic [7:0]        cfg;                             // Config being written
    int                n_mismatch, cmp_count, p;

    pad_function_mux #(.NUM_PADS(NP)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .func_out(func_out), .func_oe(func_oe), .func_in(func_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_drive(pad_drive),
        .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn));
    pad_partner #(.NUM_PADS(NP)) partner (.out_pat(out_pat), .oe_pat(oe_pat), .ext_lvl(ext_lvl),
        .func_out(func_out), .func_oe(func_oe), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));

    // Free-running system clock, 100 MHz
    always #5 aclk = ~aclk;

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task give_verdict;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Compare one value; case inequality so unknowns never match
    task check(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // ----------------------------------------
    // Register bus master
    // ----------------------------------------
    // Offer address and data together, drop each once taken, wait for the response
    task axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s,
                input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        s_axi_wstrb  <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        // Bounded wait; a hang counts against the run
        if (n == 50) n_mismatch++;
        if (n == 50) give_verdict();
        s_axi_bready <= 1'b0;
        check("bresp", er, s_axi_bresp);
    endtask : axi_wr

    // Single read, data and response taken one edge after rvalid is first seen
    task axi_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            // Accept one cycle late so the slave must hold its answer
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        if (n == 50) n_mismatch++;
        if (n == 50) give_verdict();
        s_axi_rready <= 1'b0;
        check("rdata", ed, s_axi_rdata);
        check("rresp", er, s_axi_rresp);
    endtask : axi_rd

    // ----------------------------------------
    // Whole-state comparison
    // ----------------------------------------
    // Pad outputs, function inputs and every register against the expected configs
    task check_all;
        logic [NF-1:0]   e_fin;
        logic [NP-1:0]   e_out, e_oe, lvl, e_pu, e_pd;
        logic [2*NP-1:0] e_drv;
        logic [3:0]      m;
        // Settling: one pad stage, then sync and output stage on the way back
        repeat (6) @(posedge aclk);
        e_fin = '0;
        for (int q = 0; q < NP; q++)
        begin
            m = cfg_exp[q][3:0];
            e_out[q] = out_pat[q*16+m];
            e_oe[q] = oe_pat[q*16+m];
            lvl[q] = e_oe[q] ? e_out[q] : ext_lvl[q];
            e_fin[q*16+m] = lvl[q];
            // Unused drive code shows as the strongest level
            e_drv[2*q+:2] = (cfg_exp[q][5:4] == 2'b11) ? DRIVE_6MA : cfg_exp[q][5:4];
            e_pu[q] = cfg_exp[q][6];
            e_pd[q] = cfg_exp[q][7];
        end
        check("pad_out", 64'(e_out), 64'(pad_out));
        check("pad_oe", 64'(e_oe), 64'(pad_oe));
        check("func_in", 64'(e_fin), 64'(func_in));
        check("pad_drive", 64'(e_drv), 64'(pad_drive));
        check("pad_pull_up", 64'(e_pu), 64'(pad_pull_up));
        check("pad_pull_dn", 64'(e_pd), 64'(pad_pull_dn));
        for (int q = 0; q < NP; q++)
            axi_rd(PAD_CFG_BASE + ADDR_W'(4*q), {24'h0, cfg_exp[q]}, RESP_OKAY);
        axi_rd(PAD_IN_ADDR, DATA_W'(lvl), RESP_OKAY);
    endtask : check_all

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        // Only the mode-1 functions enable their drivers during boot
        out_pat = PAT_O;
        oe_pat = 64'h0002_0002_0002_0002;
        ext_lvl = 4'h5;
        n_mismatch = 0;
        cmp_count = 0;
        foreach (cfg_exp[q]) cfg_exp[q] = CFG_RESET;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        // Boot: debug and flash pads to mode 1, the rest stay Hi-Z
        for (p = 0; p < 2; p++)
        begin
            axi_wr(PAD_CFG_BASE + ADDR_W'(4*p), 32'h0000_0001, 4'hF, RESP_OKAY);
            cfg_exp[p] = 8'h01;
        end
        check_all();
        // Every mode, each on two pads, with drive and pull fields varied, both polarities
        for (int k = 0; k < 2; k++)
            for (int m = 0; m < 16; m++)
            begin
                out_pat <= k ? ~PAT_O : PAT_O;
                oe_pat <= k ? ~PAT_E : PAT_E;
                ext_lvl <= k ? 4'hA : 4'h5;
                p = (m + k) % NP;
                cfg = {m[3:2], 2'(m), 4'(m)};
                axi_wr(PAD_CFG_BASE + ADDR_W'(4*p), {24'h0, cfg}, 4'hF, RESP_OKAY);
                cfg_exp[p] = cfg;
                check_all();
            end
        // Unmapped, unaligned, read-only and masked accesses leave configs alone
        axi_wr(12'h200, 32'h0000_00FF, 4'hF, RESP_SLVERR);
        axi_wr(12'h002, 32'h0000_00FF, 4'hF, RESP_SLVERR);
        axi_wr(PAD_IN_ADDR, 32'h0000_000F, 4'hF, RESP_OKAY);
        axi_wr(PAD_CFG_BASE + 12'h00C, 32'h0000_00A3, 4'hE, RESP_OKAY);
        axi_rd(12'h200, 32'h0, RESP_SLVERR);
        check_all();
        // Reset in mid-run returns every pad to mode 0
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (cfg_exp[q]) cfg_exp[q] = CFG_RESET;
        check_all();
        give_verdict();
    end
endmodule : pad_function_multiplexer_test
